// ==== hw/tcln_consts.svh ====
`ifndef TCLN_CONSTS_SVH
`define TCLN_CONSTS_SVH
// Summary of operation
// - characters are 7-bit ASCII, even parity, two stops
// - bit notify to bit area touches one bit
// - word area notifications are whole-word writes
// - momentary input clears other word bits
// - word access to bit area needs 16-aligned start
// - timers and counters take word writes only
// - other word areas take bit and word notifies
// - BCD or binary, global or per memory table
// - binary representation is sent without conversion

// ----------------------------------------------------------------
// clock and character format
// ----------------------------------------------------------------
`define TCLN_CLK_HZ      200000000
`define TCLN_BAUD_LO     9600
`define TCLN_BAUD_HI     19200
`define TCLN_DATA_BITS   7
`define TCLN_STOP_BITS   2
`define TCLN_FRAME_BITS  11
`define TCLN_RX_BITS     10

// ----------------------------------------------------------------
// command framing
// ----------------------------------------------------------------
`define TCLN_FRAME_CHARS 4'h9
`define TCLN_CH_BITWR    7'h42
`define TCLN_CH_WORDWR   7'h57
`define TCLN_ALIGN_LSB   4'h0
`define TCLN_BUF_DEPTH   2'h2
`endif

// ==== hw/tcln_pkg.sv ====
package tcln_pkg;
    typedef enum logic [1:0] {
        TCLN_AREA_BIT  = 2'b00,
        TCLN_AREA_WORD = 2'b01,
        TCLN_AREA_TC   = 2'b10
    } tcln_area_e;

    typedef struct packed {
        tcln_area_e  area;
        logic        word_op;
        logic [15:0] dev_num;
        logic [3:0]  bit_idx;
        logic        bit_val;
        logic [15:0] value;
        logic        momentary;
        logic        tbl_ovr;
        logic        tbl_bcd;
    } tcln_req_s;

    typedef struct packed {
        logic        word_wr;
        logic [15:0] addr;
        logic [15:0] data;
    } tcln_cmd_s;

    typedef enum logic [0:0] {
        TCLN_TX_IDLE = 1'b0,
        TCLN_TX_SEND = 1'b1
    } tcln_tx_e;

    typedef enum logic [1:0] {
        TCLN_RX_IDLE  = 2'b00,
        TCLN_RX_START = 2'b01,
        TCLN_RX_DATA  = 2'b10
    } tcln_rx_e;
endpackage

// ==== hw/tcln_notify.sv ====
`timescale 1ns/10ps
`include "tcln_consts.svh"

module tcln_notify #(
    parameter logic [15:0] DIV_LO = 16'(`TCLN_CLK_HZ / `TCLN_BAUD_LO),
    parameter logic [15:0] DIV_HI = 16'(`TCLN_CLK_HZ / `TCLN_BAUD_HI)
) (
    // clock and reset
    input  wire logic                mclk_in,
    input  wire logic                resetn_in,
    // configuration
    input  wire logic                baud_hi_in,
    input  wire logic                global_bcd_in,
    // notification requests
    input  wire logic                req_valid_in,
    input  tcln_pkg::tcln_req_s      req_in,
    output logic                     req_ready_out,
    output logic                     req_reject_out,
    // serial link
    output logic                     txd_out,
    input  wire logic                rxd_in,
    // received characters
    output logic                     rx_valid_out,
    output logic [6:0]               rx_char_out,
    output logic                     rx_err_out
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] bcd_to_bin(input logic [15:0] v);
        bcd_to_bin = ({12'h000, v[15:12]} * 16'h03E8) + ({12'h000, v[11:8]} * 16'h0064)
                   + ({12'h000, v[7:4]} * 16'h000A) + {12'h000, v[3:0]};
    endfunction

    function automatic logic [6:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'hA) ? (7'h30 + {3'h0, n}) : (7'h37 + {3'h0, n});
    endfunction

    function automatic logic [6:0] frame_char(input tcln_pkg::tcln_cmd_s c,
                                              input logic [3:0] i);
        logic [31:0] f;
        f = {c.addr, c.data};
        if (i == 4'h0) begin
            frame_char = c.word_wr ? `TCLN_CH_WORDWR : `TCLN_CH_BITWR;
        end else begin
            frame_char = hex_char(f[(4'h8 - i) * 4 +: 4]);
        end
    endfunction

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    wire logic        use_bcd   = req_in.tbl_ovr ? req_in.tbl_bcd : global_bcd_in;
    wire logic [15:0] num_val   = use_bcd ? bcd_to_bin(req_in.value) : req_in.value;
    wire logic [15:0] bit_mask  = 16'h0001 << req_in.bit_idx;
    wire logic [15:0] set_word  = req_in.bit_val ? bit_mask : 16'h0000;
    wire logic [15:0] merged    = (req_in.value & ~bit_mask) | set_word;
    wire logic [15:0] bitop_wd  = req_in.momentary ? set_word : merged;
    wire logic        misalign  = req_in.dev_num[3:0] != `TCLN_ALIGN_LSB;
    wire logic        bad_bit   = req_in.area == tcln_pkg::TCLN_AREA_BIT
                                  && req_in.word_op && misalign;
    wire logic        bad_tc    = req_in.area == tcln_pkg::TCLN_AREA_TC
                                  && !req_in.word_op;
    wire logic        bad_area  = req_in.area == 2'b11;
    wire logic        reject    = bad_bit || bad_tc || bad_area;
    wire logic        single    = req_in.area == tcln_pkg::TCLN_AREA_BIT
                                  && !req_in.word_op;

    tcln_pkg::tcln_cmd_s new_cmd;
    always_comb begin
        new_cmd.addr = req_in.dev_num;
        if (single) begin
            new_cmd.word_wr = 1'b0;
            new_cmd.data    = {15'h0000, req_in.bit_val};
        end else if (req_in.word_op) begin
            new_cmd.word_wr = 1'b1;
            new_cmd.data    = num_val;
        end else begin
            new_cmd.word_wr = 1'b1;
            new_cmd.data    = bitop_wd;
        end
    end

    // ----------------------------------------------------------------
    // two-entry command buffer
    // ----------------------------------------------------------------
    tcln_pkg::tcln_cmd_s buf_q [2];
    logic                wr_ptr_q;
    logic                rd_ptr_q;
    logic [1:0]          count_q;
    logic                pop;

    wire logic take = req_valid_in && req_ready_out;
    wire logic push = take && !reject;
    assign req_ready_out  = count_q != `TCLN_BUF_DEPTH;
    assign req_reject_out = take && reject;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            count_q  <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge mclk_in) begin
        if (push) begin
            buf_q[wr_ptr_q] <= new_cmd;
        end
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    wire logic [15:0] div = baud_hi_in ? DIV_HI : DIV_LO;

    tcln_pkg::tcln_tx_e  tx_st_q;
    tcln_pkg::tcln_cmd_s tx_cmd_q;
    logic [3:0]          chr_idx_q;
    logic [3:0]          bit_idx_q;
    logic [15:0]         tx_cnt_q;
    logic [10:0]         tx_sh_q;

    wire logic [6:0]  nxt_chr   = frame_char(tx_cmd_q, chr_idx_q);
    wire logic [10:0] nxt_frame = {2'b11, ^nxt_chr, nxt_chr, 1'b0};
    wire logic [6:0]  first_chr = frame_char(buf_q[rd_ptr_q], 4'h0);
    wire logic [10:0] first_frm = {2'b11, ^first_chr, first_chr, 1'b0};
    wire logic        bit_end   = tx_cnt_q == div - 16'h0001;
    wire logic        chr_end   = bit_end && bit_idx_q == 4'(`TCLN_FRAME_BITS - 1);
    wire logic        frm_end   = chr_end && chr_idx_q == `TCLN_FRAME_CHARS;
    assign pop = tx_st_q == tcln_pkg::TCLN_TX_IDLE && count_q != 2'h0;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_st_q   <= tcln_pkg::TCLN_TX_IDLE;
            tx_cmd_q  <= '0;
            chr_idx_q <= 4'h0;
            bit_idx_q <= 4'h0;
            tx_cnt_q  <= 16'h0000;
            tx_sh_q   <= 11'h7FF;
        end else begin
            case (tx_st_q)
                tcln_pkg::TCLN_TX_IDLE: begin
                    if (pop) begin
                        tx_st_q   <= tcln_pkg::TCLN_TX_SEND;
                        tx_cmd_q  <= buf_q[rd_ptr_q];
                        tx_sh_q   <= first_frm;
                        chr_idx_q <= 4'h1;
                        bit_idx_q <= 4'h0;
                        tx_cnt_q  <= 16'h0000;
                    end
                end
                tcln_pkg::TCLN_TX_SEND: begin
                    tx_cnt_q <= bit_end ? 16'h0000 : tx_cnt_q + 16'h0001;
                    if (frm_end) begin
                        tx_st_q <= tcln_pkg::TCLN_TX_IDLE;
                        tx_sh_q <= 11'h7FF;
                    end else if (chr_end) begin
                        tx_sh_q   <= nxt_frame;
                        chr_idx_q <= chr_idx_q + 4'h1;
                        bit_idx_q <= 4'h0;
                    end else if (bit_end) begin
                        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                        bit_idx_q <= bit_idx_q + 4'h1;
                    end
                end
                default: begin
                    tx_st_q <= tcln_pkg::TCLN_TX_IDLE;
                end
            endcase
        end
    end

    assign txd_out = tx_sh_q[0];

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    tcln_pkg::tcln_rx_e rx_st_q;
    logic [15:0]        rx_cnt_q;
    logic [3:0]         rx_bit_q;
    logic [9:0]         rx_sh_q;
    logic               rx_done_q;

    wire logic       rx_half   = rx_cnt_q == {1'b0, div[15:1]};
    wire logic       rx_full   = rx_cnt_q == div - 16'h0001;
    wire logic       rx_last   = rx_full && rx_bit_q == 4'(`TCLN_RX_BITS - 1);
    wire logic [9:0] rx_word   = {rxd_in, rx_sh_q[9:1]};
    wire logic       rx_bad    = (^rx_sh_q[7:0]) || !(&rx_sh_q[9:8]);

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_st_q   <= tcln_pkg::TCLN_RX_IDLE;
            rx_cnt_q  <= 16'h0000;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 10'h000;
            rx_done_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            case (rx_st_q)
                tcln_pkg::TCLN_RX_IDLE: begin
                    rx_cnt_q <= 16'h0000;
                    if (!rxd_in) begin
                        rx_st_q <= tcln_pkg::TCLN_RX_START;
                    end
                end
                tcln_pkg::TCLN_RX_START: begin
                    rx_cnt_q <= rx_cnt_q + 16'h0001;
                    if (rx_half) begin
                        rx_cnt_q <= 16'h0000;
                        rx_bit_q <= 4'h0;
                        rx_st_q  <= rxd_in ? tcln_pkg::TCLN_RX_IDLE : tcln_pkg::TCLN_RX_DATA;
                    end
                end
                tcln_pkg::TCLN_RX_DATA: begin
                    rx_cnt_q <= rx_full ? 16'h0000 : rx_cnt_q + 16'h0001;
                    if (rx_full) begin
                        rx_sh_q  <= rx_word;
                        rx_bit_q <= rx_bit_q + 4'h1;
                    end
                    if (rx_last) begin
                        rx_done_q <= 1'b1;
                        rx_st_q   <= tcln_pkg::TCLN_RX_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= tcln_pkg::TCLN_RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_valid_out <= 1'b0;
            rx_err_out   <= 1'b0;
            rx_char_out  <= 7'h00;
        end else begin
            rx_valid_out <= rx_done_q && !rx_bad;
            rx_err_out   <= rx_done_q && rx_bad;
            if (rx_done_q && !rx_bad) begin
                rx_char_out <= rx_sh_q[6:0];
            end
        end
    end

endmodule

// ==== bench/tcln_notify_checker.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// request and link checks
// ----------------------------------------
module tcln_notify_checker (
    // clock and reset
    input wire logic          mclk_in,
    input wire logic          resetn_in,
    // watched ports
    input wire logic          baud_hi_in,
    input wire logic          global_bcd_in,
    input wire logic          req_valid_in,
    input tcln_pkg::tcln_req_s req_in,
    input wire logic          req_ready_out,
    input wire logic          req_reject_out,
    input wire logic          txd_out,
    input wire logic          rxd_in,
    input wire logic          rx_valid_out,
    input wire logic [6:0]    rx_char_out,
    input wire logic          rx_err_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    wire       take_w = req_valid_in && req_ready_out;
    wire [1:0] area_w = req_in.area;

    reset_idle_a: assert property ($rose(resetn_in) |-> txd_out && !rx_valid_out)
        else $error("outputs not idle after reset");
    bad_area_a: assert property (take_w && area_w == 2'h3 |-> req_reject_out)
        else $error("invalid area accepted");
    tc_bit_a: assert property (take_w && area_w == 2'h2 && !req_in.word_op |-> req_reject_out)
        else $error("bit access to timer area accepted");
    align_check_a: assert property (take_w && area_w == 2'h0 && req_in.word_op
        && req_in.dev_num[3:0] != 4'h0 |-> req_reject_out) else $error("unaligned word accepted");
    word_accept_a: assert property (take_w && area_w == 2'h1 |-> !req_reject_out)
        else $error("word area request refused");
    reject_cause_a: assert property (req_reject_out |-> take_w)
        else $error("reject without request");
    rx_pulse_a: assert property (rx_valid_out |-> !rx_err_out ##1 !rx_valid_out)
        else $error("receive flags malformed");
    rx_hold_a: assert property ($changed(rx_char_out) |-> rx_valid_out)
        else $error("received char changed without valid");
    low_width_a: assert property ($fell(txd_out) |-> (!txd_out)[*4])
        else $error("low bit too short");
    high_width_a: assert property ($rose(txd_out) |-> txd_out[*4])
        else $error("high bit too short");

    cover property (take_w && req_reject_out);
    cover property (rx_valid_out);
    cover property (rx_err_out);
endmodule

bind tcln_notify tcln_notify_checker i_tcln_notify_checker (
    .mclk_in        (mclk_in),
    .resetn_in      (resetn_in),
    .baud_hi_in     (baud_hi_in),
    .global_bcd_in  (global_bcd_in),
    .req_valid_in   (req_valid_in),
    .req_in         (req_in),
    .req_ready_out  (req_ready_out),
    .req_reject_out (req_reject_out),
    .txd_out        (txd_out),
    .rxd_in         (rxd_in),
    .rx_valid_out   (rx_valid_out),
    .rx_char_out    (rx_char_out),
    .rx_err_out     (rx_err_out)
);

// ==== bench/tcln_peer.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// controller link model
// ----------------------------------------
module tcln_peer (
    // clock and bit period
    input wire logic        clk_in,
    input wire logic [15:0] div_in,
    // serial lines
    input wire logic        txd_in,
    output logic            rxd_out
);
    logic [6:0] rxq [$];
    int         perr = 0;
    logic [9:0] sh;
    initial rxd_out = 1'b1;

    // mid-bit sampling at the rate agreed with the terminal
    always begin
        @(negedge txd_in);
        repeat (div_in / 2) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            repeat (div_in) @(posedge clk_in);
            sh[i] = txd_in;
        end
        if (^sh[7:0] || sh[9:8] != 2'b11) perr++;
        else rxq.push_back(sh[6:0]);
    end

    function automatic logic [6:0] pop();
        return (rxq.size() > 0) ? rxq.pop_front() : 7'h7F;
    endfunction

    task automatic send_char(input logic [6:0] c, input logic bad_par, input logic bad_stop);
        logic [10:0] f;
        f = {1'b1, ~bad_stop, ^c ^ bad_par, c, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd_out = f[i];
            repeat (div_in) @(posedge clk_in);
            #1;
        end
        rxd_out = 1'b1;
        // one idle cycle after the stop bits, so back-to-back calls leave a gap before the next start bit
        @(posedge clk_in) #1;
    endtask
endmodule

// ==== bench/tcln_notify_tb.sv ====
`timescale 1ns/10ps
module tcln_notify_tb;
    logic                mclk_in = 1'b0;
    logic                resetn_in = 1'b0;
    logic                baud_hi_in = 1'b0;
    logic                global_bcd_in = 1'b0;
    logic                req_valid_in = 1'b0;
    tcln_pkg::tcln_req_s req_in = '0;
    logic                req_ready_out, req_reject_out, txd_out, rxd_in;
    logic                rx_valid_out, rx_err_out;
    logic [6:0]          rx_char_out;
    int                  err_total = 0, comparisons = 0, cyc = 0, nv = 0, ne = 0;

    always #2.5 mclk_in = ~mclk_in;
    tcln_notify #(.DIV_LO(16'h0008), .DIV_HI(16'h0004)) i_tcln_notify (
        .mclk_in        (mclk_in),
        .resetn_in      (resetn_in),
        .baud_hi_in     (baud_hi_in),
        .global_bcd_in  (global_bcd_in),
        .req_valid_in   (req_valid_in),
        .req_in         (req_in),
        .req_ready_out  (req_ready_out),
        .req_reject_out (req_reject_out),
        .txd_out        (txd_out),
        .rxd_in         (rxd_in),
        .rx_valid_out   (rx_valid_out),
        .rx_char_out    (rx_char_out),
        .rx_err_out     (rx_err_out)
    );
    tcln_peer i_tcln_peer (.clk_in(mclk_in), .div_in(baud_hi_in ? 16'h0004 : 16'h0008),
        .txd_in(txd_out), .rxd_out(rxd_in));

    always @(posedge mclk_in) begin
        cyc++;
        if (rx_valid_out === 1'b1) nv++;
        if (rx_err_out === 1'b1) ne++;
        if (cyc == 40000) begin
            err_total++;
            final_report;
        end
    end

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [6:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 7'h30 + 7'(n) : 7'h37 + 7'(n);
    endfunction
    // b = {bit value, bit index}, f = {momentary, override, table bcd}
    function automatic tcln_pkg::tcln_req_s mk(input logic [1:0] a, input logic w,
            input logic [15:0] dn, input logic [4:0] b, input logic [15:0] v, input logic [2:0] f);
        return '{tcln_pkg::tcln_area_e'(a), w, dn, b[3:0], b[4], v, f[2], f[1], f[0]};
    endfunction
    task automatic send(input tcln_pkg::tcln_req_s r, input logic rej, input logic hold);
        int n;
        req_in = r;
        req_valid_in = 1'b1;
        #1;
        for (n = 0; n < 5000 && req_ready_out !== 1'b1; n++) @(posedge mclk_in) #1;
        chk("ready", 16'h1, 16'(req_ready_out));
        chk("reject", 16'(rej), 16'(req_reject_out));
        @(posedge mclk_in) #1;
        if (!hold) begin
            req_valid_in = 1'b0;
            @(posedge mclk_in) #1;
        end
    endtask
    task automatic frame(input logic [6:0] k, input logic [15:0] a, input logic [15:0] d);
        logic [6:0] e [9];
        int n;
        e[0] = k;
        for (n = 0; n < 4; n++) begin
            e[1 + n] = hx(a[15 - 4 * n -: 4]);
            e[5 + n] = hx(d[15 - 4 * n -: 4]);
        end
        for (n = 0; n < 5000 && i_tcln_peer.rxq.size() < 9; n++) @(posedge mclk_in);
        for (n = 0; n < 9; n++) chk("frame char", 16'(e[n]), 16'(i_tcln_peer.pop()));
        chk("format errors", 16'h0, 16'(i_tcln_peer.perr));
        @(posedge mclk_in) #1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_bits;
        chk("txd idle", 16'h1, 16'(txd_out));
        send(mk(2'h0, 1'b0, 16'h0123, 5'h13, 16'hFFFF, 3'h0), 1'b0, 1'b0);
        frame(7'h42, 16'h0123, 16'h0001);
        send(mk(2'h1, 1'b0, 16'h0040, 5'h12, 16'hA5F0, 3'h0), 1'b0, 1'b0);
        frame(7'h57, 16'h0040, 16'hA5F4);
        send(mk(2'h1, 1'b0, 16'h0041, 5'h1F, 16'hA5F0, 3'h4), 1'b0, 1'b0);
        frame(7'h57, 16'h0041, 16'h8000);
    endtask
    task automatic t_repr;
        logic [15:0] v [5] = '{16'h1234, 16'h9999, 16'h1234, 16'h0600, 16'h0600};
        logic [15:0] x [5] = '{16'h04D2, 16'h270F, 16'h1234, 16'h0258, 16'h0600};
        logic [2:0]  f [5] = '{3'h0, 3'h0, 3'h2, 3'h3, 3'h0};
        for (int i = 0; i < 5; i++) begin
            global_bcd_in = (i < 3);
            send(mk(2'h1, 1'b1, 16'h0100, 5'h00, v[i], f[i]), 1'b0, 1'b0);
            frame(7'h57, 16'h0100, x[i]);
        end
    endtask
    task t_refuse;
        send(mk(2'h3, 1'b1, 16'h0000, 5'h00, 16'h0001, 3'h0), 1'b1, 1'b0);
        send(mk(2'h2, 1'b0, 16'h0005, 5'h11, 16'h0001, 3'h0), 1'b1, 1'b0);
        send(mk(2'h0, 1'b1, 16'h0011, 5'h00, 16'h0001, 3'h0), 1'b1, 1'b0);
        send(mk(2'h0, 1'b1, 16'h0020, 5'h00, 16'hBEEF, 3'h0), 1'b0, 1'b0);
        frame(7'h57, 16'h0020, 16'hBEEF);
    endtask
    task t_burst;
        for (int i = 0; i < 4; i++) begin
            send(mk(2'h2, 1'b1, 16'(i), 5'h00, 16'h0100 + 16'(i), 3'h0), 1'b0, i < 2);
            if (i == 2) chk("buffer full", 16'h0, 16'(req_ready_out));
        end
        for (int i = 0; i < 4; i++) frame(7'h57, 16'(i), 16'h0100 + 16'(i));
    endtask
    task automatic t_rx;
        int v0 = nv;
        int e0 = ne;
        i_tcln_peer.send_char(7'h35, 1'b0, 1'b0);
        repeat (4) @(posedge mclk_in) #1;
        chk("rx char", 16'h0035, 16'(rx_char_out));
        i_tcln_peer.send_char(7'h2A, 1'b1, 1'b0);
        i_tcln_peer.send_char(7'h2A, 1'b0, 1'b1);
        repeat (4) @(posedge mclk_in) #1;
        chk("rx good", 16'(v0 + 1), 16'(nv));
        chk("rx errors", 16'(e0 + 2), 16'(ne));
        chk("rx kept", 16'h0035, 16'(rx_char_out));
    endtask
    task t_baud;
        repeat (20) @(posedge mclk_in) #1;
        baud_hi_in = 1'b1;
        send(mk(2'h1, 1'b1, 16'h0200, 5'h00, 16'h00C3, 3'h0), 1'b0, 1'b0);
        frame(7'h57, 16'h0200, 16'h00C3);
        t_rx;
    endtask

    task final_report;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge mclk_in);
        #1;
        resetn_in = 1'b1;
        t_bits;
        t_repr;
        t_refuse;
        t_burst;
        t_rx;
        t_baud;
        final_report;
    end
endmodule
